// [shared/escl_map.vh]
// Constants for the start-up configuration loader
`ifndef ESCL_MAP_VH
`define ESCL_MAP_VH
`define ESCL_MEM_BYTES      128
`define ESCL_MEM_AW         7
`define ESCL_BLK0_LAST      7'h0F
`define ESCL_INIT_FIRST     7'h10
`define ESCL_INIT_LAST      7'h2F
`define ESCL_PAGE_LOW3      3'h0
`define ESCL_CHK_POS        4'hF
`define ESCL_RSMAX_POS      4'hE
`define ESCL_TRIM0_POS      4'hC
`define ESCL_TRIM1_POS      4'hD
`define ESCL_SER_FIRST      4'h8
`define ESCL_VER_POS        4'h4
`define ESCL_CHK_SEED       8'hFF
`define ESCL_CHK_POLY       8'h1D
`define ESCL_RES_VAL        8'h00
`define ESCL_PAGE_RST       8'h00
`endif

// [logic/escl_config_loader.v]
// Start-up configuration loader: non-volatile store, info field check, register copy
`timescale 1ns/1ps
`include "escl_map.vh"

// Overview of operation
// - Eight blocks of sixteen bytes, block zero read-only
// - Check byte fifteen verified during start-up
// - Byte fourteen holds maximum driver source resistance
// - Bytes twelve, thirteen hold read-only trimming
// - Bytes eight to eleven hold serial number
// - Bytes zero to four identify; five-seven reserved
// - After reset copy memory into registers 10h-2Fh
// - Load-configuration command repeats the register copy
// - Page register aliases skipped, left unchanged
// - Memory byte address equals target register address
// - Copy uses current file contents every time
module escl_config_loader
#(
	parameter [7:0] TYPE_ID0  = 8'hA5, // Arbitrary identity value
	parameter [7:0] TYPE_ID1  = 8'h5A, // Arbitrary identity value
	parameter [7:0] TYPE_ID2  = 8'hC3, // Arbitrary identity value
	parameter [7:0] TYPE_ID3  = 8'h3C, // Arbitrary identity value
	parameter [7:0] SILICON_VER = 8'h01, // Arbitrary identity value
	parameter [31:0] SERIAL_NUM = 32'h1234_5678, // Arbitrary per-device value
	parameter [7:0] RSMAX_OHM = 8'h64,
	parameter [15:0] TRIM_VAL = 16'h0000
)
(
	input  wire       i_ref_clk,
	input  wire       i_sys_rst,
	input  wire       i_load_configuration_command,
	input  wire       i_mem_wr,
	input  wire [6:0] i_mem_addr,
	input  wire [7:0] i_mem_wdata,
	output reg  [7:0] o_mem_rdata,
	output wire       o_busy,
	output reg        o_info_ok,
	output reg        o_reg_we,
	output reg  [5:0] o_reg_addr,
	output reg  [7:0] o_reg_wdata
);

	//----------------------------------------
	// State encoding
	//----------------------------------------
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_CHECK = 2'h1;
	localparam [1:0] ST_COPY  = 2'h2;

	//----------------------------------------
	// Storage and sequencer state
	//----------------------------------------
	reg [7:0] mem [0:`ESCL_MEM_BYTES-1];
	reg [1:0] state;
	reg [1:0] next_state;
	reg [6:0] ptr;
	reg [6:0] next_ptr;
	reg [7:0] chk;
	reg       pend_load;
	integer   k;

	//----------------------------------------
	// Address decode
	//----------------------------------------
	wire [7:0] cur_byte = mem[ptr];
	wire       is_page  = (ptr[2:0] == `ESCL_PAGE_LOW3);
	wire       in_info  = (i_mem_addr <= `ESCL_BLK0_LAST);
	wire       host_ok  = i_mem_wr && !in_info;

	//----------------------------------------
	// Check step: CRC over bytes 0..14, MSB first
	//----------------------------------------
	function [7:0] chk_step;
		input [7:0] acc;
		input [7:0] d;
		reg   [7:0] t;
		integer     b;
		begin
			t = acc ^ d;
			for (b = 0; b < 8; b = b + 1)
			begin
				t = t[7] ? ({t[6:0], 1'b0} ^ `ESCL_CHK_POLY) : {t[6:0], 1'b0};
			end
			chk_step = t;
		end
	endfunction

	//----------------------------------------
	// Factory image of block zero
	//----------------------------------------
	function [7:0] info_byte;
		input [3:0] pos;
		begin
			case (pos)
				4'h0: info_byte = TYPE_ID0;
				4'h1: info_byte = TYPE_ID1;
				4'h2: info_byte = TYPE_ID2;
				4'h3: info_byte = TYPE_ID3;
				`ESCL_VER_POS: info_byte = SILICON_VER;
				4'h5, 4'h6, 4'h7: info_byte = `ESCL_RES_VAL;
				4'h8: info_byte = SERIAL_NUM[7:0];
				4'h9: info_byte = SERIAL_NUM[15:8];
				4'hA: info_byte = SERIAL_NUM[23:16];
				4'hB: info_byte = SERIAL_NUM[31:24];
				`ESCL_TRIM0_POS: info_byte = TRIM_VAL[7:0];
				`ESCL_TRIM1_POS: info_byte = TRIM_VAL[15:8];
				`ESCL_RSMAX_POS: info_byte = RSMAX_OHM;
				default: info_byte = `ESCL_RES_VAL;
			endcase
		end
	endfunction

	function [7:0] info_chk;
		input dummy;
		reg   [7:0] a;
		integer     p;
		begin
			a = `ESCL_CHK_SEED;
			for (p = 0; p < 15; p = p + 1)
			begin
				a = chk_step(a, info_byte(p[3:0]));
			end
			info_chk = a;
		end
	endfunction

	//----------------------------------------
	// Non-volatile store
	//----------------------------------------
	always @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			// Block zero rebuilt from parameters at every reset
			for (k = 0; k < 16; k = k + 1)
			begin
				if (k == 15)
				begin
					mem[k] <= info_chk(1'b0);
				end
				else
				begin
					mem[k] <= info_byte(k[3:0]);
				end
			end
		end
		else if (host_ok && !o_busy)
		begin
			mem[i_mem_addr] <= i_mem_wdata;
		end
	end

	always @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_mem_rdata <= 8'h00;
		end
		else
		begin
			o_mem_rdata <= mem[i_mem_addr];
		end
	end

	//----------------------------------------
	// Sequencer
	//----------------------------------------
	always @*
	begin
		next_state = state;
		next_ptr   = ptr;
		case (state)
			ST_IDLE:
			begin
				// Pending or fresh command starts a pass
				if (pend_load || i_load_configuration_command)
				begin
					next_state = ST_COPY;
					next_ptr   = `ESCL_INIT_FIRST;
				end
			end
			ST_CHECK:
			begin
				if (ptr[3:0] == `ESCL_CHK_POS)
				begin
					next_state = ST_COPY;
					next_ptr   = `ESCL_INIT_FIRST;
				end
				else
				begin
					next_ptr = ptr + 7'h01;
				end
			end
			ST_COPY:
			begin
				// Last target address ends the copy
				if (ptr == `ESCL_INIT_LAST)
				begin
					next_state = ST_IDLE;
				end
				else
				begin
					next_ptr = ptr + 7'h01;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
				next_ptr   = 7'h00;
			end
		endcase
	end

	//----------------------------------------
	// State and pointer registers
	//----------------------------------------
	always @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			state <= ST_CHECK;
			ptr   <= 7'h00;
		end
		else
		begin
			state <= next_state;
			ptr   <= next_ptr;
		end
	end

	//----------------------------------------
	// Command queued while busy
	//----------------------------------------
	always @(posedge i_ref_clk)
	begin
		// One command is kept; it runs after the current pass
		if (i_sys_rst)
		begin
			pend_load <= 1'b0;
		end
		else if (state != ST_IDLE && i_load_configuration_command)
		begin
			pend_load <= 1'b1;
		end
		else if (state == ST_IDLE)
		begin
			pend_load <= 1'b0;
		end
	end

	//----------------------------------------
	// Product information check
	//----------------------------------------
	always @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			chk       <= `ESCL_CHK_SEED;
			o_info_ok <= 1'b0;
		end
		else if (state == ST_CHECK)
		begin
			// Byte fifteen holds the expected check value
			if (ptr[3:0] == `ESCL_CHK_POS)
			begin
				o_info_ok <= (chk == cur_byte);
			end
			else
			begin
				chk <= chk_step(chk, cur_byte);
			end
		end
	end

	//----------------------------------------
	// Register load port
	//----------------------------------------
	always @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_reg_we    <= 1'b0;
			o_reg_addr  <= 6'h00;
			o_reg_wdata <= 8'h00;
		end
		else
		begin
			// Page aliases never reach the register file
			o_reg_we    <= (state == ST_COPY) && !is_page;
			o_reg_addr  <= ptr[5:0];
			o_reg_wdata <= cur_byte;
		end
	end

	//----------------------------------------
	// Status
	//----------------------------------------
	assign o_busy = (state != ST_IDLE);

endmodule

// [verif/escl_config_loader_props.sv]
// Checker for the start-up configuration loader
`timescale 1ns/1ps
module escl_props (
	input wire       i_ref_clk,
	input wire       i_sys_rst,
	input wire       i_load_configuration_command,
	input wire [6:0] i_mem_addr,
	input wire [7:0] o_mem_rdata,
	input wire       o_busy,
	input wire       o_info_ok,
	input wire       o_reg_we,
	input wire [5:0] o_reg_addr
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_cmd; i_load_configuration_command && !o_busy; endsequence
	sequence s_go; ##1 o_busy ##2 o_reg_we && o_reg_addr == 6'h11; endsequence
	property p_go; s_cmd |-> s_go; endproperty
	a_go: assert property (p_go) else $error("bad copy start");
	property p_skip; o_reg_we |-> o_reg_addr[2:0] != 3'h0; endproperty
	a_skip: assert property (p_skip) else $error("page loaded");
	property p_range; o_reg_we |-> o_reg_addr >= 6'h11 && o_reg_addr <= 6'h2F; endproperty
	a_range: assert property (p_range) else $error("bad target");
	property p_step; o_reg_we && $past(o_reg_we) |-> o_reg_addr == $past(o_reg_addr) + 6'h1;
	endproperty
	a_step: assert property (p_step) else $error("bad order");
	property p_rom; (i_mem_addr < 7'h10) ##1 ($stable(i_mem_addr) && !$past(i_sys_rst))
		|=> $stable(o_mem_rdata);
	endproperty
	a_rom: assert property (p_rom) else $error("info changed");
	property p_hold; o_info_ok |=> o_info_ok; endproperty
	a_hold: assert property (p_hold) else $error("check lost");
	property p_boot; $fell(i_sys_rst) |-> o_busy ##[1:40] o_reg_we; endproperty
	a_boot: assert property (p_boot) else $error("no boot copy");
	property p_quiet; !o_busy [*3] |-> !o_reg_we; endproperty
	a_quiet: assert property (p_quiet) else $error("idle load");
endmodule
bind escl_config_loader escl_props u_props (
	.i_ref_clk                    (i_ref_clk),
	.i_sys_rst                    (i_sys_rst),
	.i_load_configuration_command (i_load_configuration_command),
	.i_mem_addr                   (i_mem_addr),
	.o_mem_rdata                  (o_mem_rdata),
	.o_busy                       (o_busy),
	.o_info_ok                    (o_info_ok),
	.o_reg_we                     (o_reg_we),
	.o_reg_addr                   (o_reg_addr)
);

// [verif/escl_config_loader_tb_top.sv]
// Bench for the start-up configuration loader
`timescale 1ns/1ps
module escl_config_loader_tb_top;
	reg        clk = 0, rst = 1, cmd = 0, wr = 0;
	reg  [6:0] a = 0;
	reg  [7:0] d = 0, pat = 0;
	wire [7:0] rd, rwd;
	wire [5:0] ra;
	wire       busy, ok, we;
	integer    num_errors = 0, n_checks = 0, i, nld = 0;
	reg [15:0] rows [0:12];
	escl_config_loader uut (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_load_configuration_command(cmd), .i_mem_wr(wr), .i_mem_addr(a),
		.i_mem_wdata(d), .o_mem_rdata(rd), .o_busy(busy), .o_info_ok(ok),
		.o_reg_we(we), .o_reg_addr(ra), .o_reg_wdata(rwd));
	initial
		forever #4 clk = ~clk;
	task chk(input string s, input [7:0] e, input [7:0] g);
	begin
		n_checks = n_checks + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("Error %s exp %h got %h", s, e, g);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	task wrb(input [6:0] x, input [7:0] y);
	begin
		@(posedge clk) {wr, a, d} <= {1'b1, x, y};
		@(posedge clk) wr <= 0;
	end
	endtask
	task rdb(input [6:0] x, input [7:0] e);
	begin
		@(posedge clk) a <= x;
		@(negedge clk);
		@(negedge clk);
		chk("rdata", e, rd);
	end
	endtask
	task cmd1;
	begin
		@(posedge clk) cmd <= 1;
		@(posedge clk) cmd <= 0;
	end
	endtask
	// Preset bytes keep their delivered zero value in every file
	function [7:0] img(input [6:0] x);
		img = (x == 7'h17 || x == 7'h1D || x == 7'h25 || x == 7'h27) ? 8'h00 : {1'b0, x} ^ pat;
	endfunction
	task fill(input [7:0] p);
	begin
		pat = p;
		for (i = 16; i < 48; i = i + 1)
			wrb(i[6:0], img(i[6:0]));
	end
	endtask
	always @(negedge clk)
		if (pat != 0 && we === 1'b1)
		begin
			nld = nld + 1;
			chk("load", img({1'b0, ra}), rwd);
		end
	initial
	begin
		#20000 num_errors = num_errors + 1;
		finish_test;
	end
	// ---
	// Tests
	// ---
	initial
	begin
		rows = '{16'h00A5, 16'h015A, 16'h02C3, 16'h033C, 16'h0401, 16'h0500, 16'h0700,
			16'h0878, 16'h0956, 16'h0A34, 16'h0B12, 16'h0C00, 16'h0E64};
		repeat (2) @(posedge clk);
		rst <= 0;
		repeat (60) @(posedge clk);
		@(negedge clk);
		chk("info_ok", 1, ok);
		chk("busy", 0, busy);
		for (i = 0; i < 13; i = i + 1)
			rdb(rows[i][14:8], rows[i][7:0]);
		$display("rom done");
		wrb(7'h04, 8'hEE);
		rdb(7'h04, 8'h01);
		fill(8'h5A);
		cmd1;
		repeat (40) @(posedge clk);
		chk("loads", 28, nld[7:0]);
		$display("copy done");
		fill(8'hA5);
		cmd1;
		repeat (5) @(posedge clk);
		cmd1;
		repeat (80) @(posedge clk);
		chk("loads", 84, nld[7:0]);
		$display("queue done");
		@(posedge clk) rst <= 1;
		@(posedge clk);
		@(negedge clk);
		chk("busy", 1, busy);
		chk("info_ok", 0, ok);
		chk("rdata", 0, rd);
		@(posedge clk) rst <= 0;
		repeat (60) @(posedge clk);
		@(negedge clk);
		chk("info_ok", 1, ok);
		chk("busy", 0, busy);
		chk("loads", 112, nld[7:0]);
		$display("reset done");
		finish_test;
	end
endmodule
